/* shared/parity_err_pkg.sv */
package parity_err_pkg;

  localparam int NUM_PORTS = 2;

  // Transfer kinds seen by one translation_port.
  localparam logic [1:0] KIND_OUT_RD = 2'h0;
  localparam logic [1:0] KIND_OUT_WR = 2'h1;
  localparam logic [1:0] KIND_IN_RD  = 2'h2;
  localparam logic [1:0] KIND_IN_WR  = 2'h3;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [31:0] OFS_PRI_CMD   = 32'h0000_0000;
  localparam logic [31:0] OFS_PRI_STS   = 32'h0000_0004;
  localparam logic [31:0] OFS_PRI_IMASK = 32'h0000_0008;
  localparam logic [31:0] OFS_PRI_ISR   = 32'h0000_000c;
  localparam logic [31:0] OFS_SEC_CMD   = 32'h0000_0010;
  localparam logic [31:0] OFS_SEC_STS   = 32'h0000_0014;
  localparam logic [31:0] OFS_SEC_IMASK = 32'h0000_0018;
  localparam logic [31:0] OFS_SEC_ISR   = 32'h0000_001c;

  // Register selectors inside one port.
  localparam logic [1:0] SEL_CMD   = 2'h0;
  localparam logic [1:0] SEL_STS   = 2'h1;
  localparam logic [1:0] SEL_IMASK = 2'h2;
  localparam logic [1:0] SEL_ISR   = 2'h3;

  // Field positions.
  localparam int CMD_PERE_BIT = 0;
  localparam int MPE_BIT      = 0;
  localparam int DPE_BIT      = 1;

  // Values after reset.
  localparam logic       CMD_RESET   = 1'b0;
  localparam logic [1:0] STS_RESET   = 2'h0;
  localparam logic [1:0] IMASK_RESET = 2'h0;
  localparam logic [1:0] ISR_RESET   = 2'h0;

  typedef enum logic [3:0] {
    B_IDLE = 4'b0001,
    B_WR   = 4'b0010,
    B_RDW  = 4'b0100,
    B_RDD  = 4'b1000
  } bus_state_t;

endpackage

/* src/even_parity.sv */
`timescale 1ns/1ps
module even_parity
  import parity_err_pkg::*;
(
  // Data phase lines.
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe_n,
  // Expected parity bit.
  output logic             exp_par
);

  // PAR makes the count of ones over AD, C/BE# and PAR even.
  assign exp_par = ^{ad, cbe_n};

endmodule

/* src/pci_data_parity_error_handler.sv */
//
// Contract
// - Outbound read passes received data, bad parity included, to the internal master.
// - Outbound read parity error never ends the transfer early.
// - Outbound read error drives PERR# two clocks later, only if enabled.
// - Outbound read error sets master parity status only if response enabled.
// - Outbound read or inbound write error always sets detected parity status.
// - Master parity error sets its interrupt status unless masked.
// - Detected parity error sets its interrupt status unless masked.
// - Outbound write keeps writing after target reports parity error.
// - Target PERR# on outbound write sets master status if enabled.
// - Outbound write error causes no completion; restart after disconnect.
// - Inbound read parity error seen by master causes no action.
// - Inbound write error keeps accepting data until completion or queue full.
// - Inbound write error drives PERR# two clocks later, only if enabled.
// - Both ports behave alike, each with its own controls and pin.
`timescale 1ns/1ps
module pci_data_parity_error_handler
  import parity_err_pkg::*;
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Primary port data phase view.
  input  wire logic        pri_xfer_active,
  input  wire logic [1:0]  pri_xfer_kind,
  input  wire logic        pri_dphase,
  input  wire logic [31:0] pri_ad,
  input  wire logic [3:0]  pri_cbe_n,
  input  wire logic        pri_par,
  // Primary parity error pin.
  input  wire logic        primary_parity_err_n_in,
  output logic             primary_parity_err_n_out,
  output logic             primary_parity_err_oe,
  // Primary internal side and flow.
  output logic [31:0]      pri_rd_data,
  output logic             pri_rd_valid,
  output logic             pri_rd_bad,
  input  wire logic        pri_eng_cmpl_req,
  input  wire logic        pri_tgt_disc,
  input  wire logic        pri_owq_empty,
  input  wire logic        pri_iq_full,
  output logic             pri_mst_cmpl,
  output logic             pri_restart_req,
  output logic             pri_tgt_accept,
  // Secondary port data phase view.
  input  wire logic        sec_xfer_active,
  input  wire logic [1:0]  sec_xfer_kind,
  input  wire logic        sec_dphase,
  input  wire logic [31:0] sec_ad,
  input  wire logic [3:0]  sec_cbe_n,
  input  wire logic        sec_par,
  // Secondary parity error pin.
  input  wire logic        secondary_parity_err_n_in,
  output logic             secondary_parity_err_n_out,
  output logic             secondary_parity_err_oe,
  // Secondary internal side and flow.
  output logic [31:0]      sec_rd_data,
  output logic             sec_rd_valid,
  output logic             sec_rd_bad,
  input  wire logic        sec_eng_cmpl_req,
  input  wire logic        sec_tgt_disc,
  input  wire logic        sec_owq_empty,
  input  wire logic        sec_iq_full,
  output logic             sec_mst_cmpl,
  output logic             sec_restart_req,
  output logic             sec_tgt_accept
);

  typedef struct packed {
    bus_state_t                 bus;
    logic                       mapped;
    logic                       slot_port;
    logic [1:0]                 slot_sel;
    logic [31:0]                rdata;
    logic [NUM_PORTS-1:0]       pere;
    logic [NUM_PORTS-1:0][1:0]  sts;
    logic [NUM_PORTS-1:0][1:0]  imask;
    logic [NUM_PORTS-1:0][1:0]  isr;
  } top_state_t;

  top_state_t           st;
  top_state_t           next_st;
  logic                 accept;
  logic [3:0]           slot;
  logic [NUM_PORTS-1:0] exp_par;
  logic [NUM_PORTS-1:0] mpe_evt;
  logic [NUM_PORTS-1:0] dpe_evt;

  // Returns {mapped, port, selector} for a byte address.
  function automatic logic [3:0] decode_slot(input logic [31:0] addr);
    logic [3:0] s;
    s = 4'h0;
    case (addr)
      OFS_PRI_CMD:   s = {1'b1, 1'b0, SEL_CMD};
      OFS_PRI_STS:   s = {1'b1, 1'b0, SEL_STS};
      OFS_PRI_IMASK: s = {1'b1, 1'b0, SEL_IMASK};
      OFS_PRI_ISR:   s = {1'b1, 1'b0, SEL_ISR};
      OFS_SEC_CMD:   s = {1'b1, 1'b1, SEL_CMD};
      OFS_SEC_STS:   s = {1'b1, 1'b1, SEL_STS};
      OFS_SEC_IMASK: s = {1'b1, 1'b1, SEL_IMASK};
      OFS_SEC_ISR:   s = {1'b1, 1'b1, SEL_ISR};
      default:       s = 4'h0;
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two identical port engines, each tied only to its own controls and pin.

  even_parity u_pri_par (
    .ad      (pri_ad),
    .cbe_n   (pri_cbe_n),
    .exp_par (exp_par[0])
  );

  even_parity u_sec_par (
    .ad      (sec_ad),
    .cbe_n   (sec_cbe_n),
    .exp_par (exp_par[1])
  );

  translation_port_parity u_pri (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .pere         (st.pere[0]),
    .xfer_active  (pri_xfer_active),
    .xfer_kind    (pri_xfer_kind),
    .dphase       (pri_dphase),
    .ad           (pri_ad),
    .exp_par      (exp_par[0]),
    .par          (pri_par),
    .perr_in_n    (primary_parity_err_n_in),
    .perr_out_n   (primary_parity_err_n_out),
    .perr_oe      (primary_parity_err_oe),
    .rd_data      (pri_rd_data),
    .rd_valid     (pri_rd_valid),
    .rd_bad       (pri_rd_bad),
    .eng_cmpl_req (pri_eng_cmpl_req),
    .tgt_disc     (pri_tgt_disc),
    .owq_empty    (pri_owq_empty),
    .iq_full      (pri_iq_full),
    .mst_cmpl     (pri_mst_cmpl),
    .restart_req  (pri_restart_req),
    .tgt_accept   (pri_tgt_accept),
    .mpe_evt      (mpe_evt[0]),
    .dpe_evt      (dpe_evt[0])
  );

  translation_port_parity u_sec (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .pere         (st.pere[1]),
    .xfer_active  (sec_xfer_active),
    .xfer_kind    (sec_xfer_kind),
    .dphase       (sec_dphase),
    .ad           (sec_ad),
    .exp_par      (exp_par[1]),
    .par          (sec_par),
    .perr_in_n    (secondary_parity_err_n_in),
    .perr_out_n   (secondary_parity_err_n_out),
    .perr_oe      (secondary_parity_err_oe),
    .rd_data      (sec_rd_data),
    .rd_valid     (sec_rd_valid),
    .rd_bad       (sec_rd_bad),
    .eng_cmpl_req (sec_eng_cmpl_req),
    .tgt_disc     (sec_tgt_disc),
    .owq_empty    (sec_owq_empty),
    .iq_full      (sec_iq_full),
    .mst_cmpl     (sec_mst_cmpl),
    .restart_req  (sec_restart_req),
    .tgt_accept   (sec_tgt_accept),
    .mpe_evt      (mpe_evt[1]),
    .dpe_evt      (dpe_evt[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and registers.

  // Only whole-word transfers are expected; other sizes are treated as words.
  assign accept = hsel && hready && htrans[1];
  assign slot   = decode_slot(haddr);

  always_comb begin
    next_st = st;
    case (st.bus)
      B_IDLE, B_WR, B_RDD: begin
        if (accept) begin
          next_st.bus       = hwrite ? B_WR : B_RDW;
          next_st.mapped    = slot[3];
          next_st.slot_port = slot[2];
          next_st.slot_sel  = slot[1:0];
        end else begin
          next_st.bus = B_IDLE;
        end
      end
      B_RDW: begin
        next_st.bus = B_RDD;
      end
      default: begin
        next_st.bus = B_IDLE;
      end
    endcase

    // The read wait state lets a write in the previous data phase land first.
    if (st.bus == B_RDW) begin
      next_st.rdata = 32'h0000_0000;
      if (st.mapped) begin
        case (st.slot_sel)
          SEL_CMD:   next_st.rdata[CMD_PERE_BIT] = st.pere[st.slot_port];
          SEL_STS:   next_st.rdata[1:0] = st.sts[st.slot_port];
          SEL_IMASK: next_st.rdata[1:0] = st.imask[st.slot_port];
          default:   next_st.rdata[1:0] = st.isr[st.slot_port];
        endcase
      end
    end

    for (int p = 0; p < NUM_PORTS; p++) begin
      if (st.bus == B_WR && st.mapped && st.slot_port == 1'(p)) begin
        case (st.slot_sel)
          SEL_CMD:   next_st.pere[p]  = hwdata[CMD_PERE_BIT];
          SEL_STS:   next_st.sts[p]   = st.sts[p] & ~hwdata[1:0];
          SEL_IMASK: next_st.imask[p] = hwdata[1:0];
          default:   next_st.isr[p]   = st.isr[p] & ~hwdata[1:0];
        endcase
      end
      // Sets come after the write-one-to-clear so an event is never lost.
      if (mpe_evt[p] && st.pere[p]) begin
        next_st.sts[p][MPE_BIT] = 1'b1;
      end
      if (dpe_evt[p]) begin
        next_st.sts[p][DPE_BIT] = 1'b1;
      end
      if (mpe_evt[p] && !st.imask[p][MPE_BIT]) begin
        next_st.isr[p][MPE_BIT] = 1'b1;
      end
      if (dpe_evt[p] && !st.imask[p][DPE_BIT]) begin
        next_st.isr[p][DPE_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st           <= '0;
      st.bus       <= B_IDLE;
      st.pere      <= {NUM_PORTS{CMD_RESET}};
      st.sts       <= {NUM_PORTS{STS_RESET}};
      st.imask     <= {NUM_PORTS{IMASK_RESET}};
      st.isr       <= {NUM_PORTS{ISR_RESET}};
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.bus != B_RDW;
  assign hrdata    = st.rdata;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_dpe_status_set: assert property (
    dpe_evt[0] |=> st.sts[0][DPE_BIT])
    else $error("Detected parity status not set on primary");

  a_mpe_status_gate: assert property (
    $rose(st.sts[0][MPE_BIT]) |-> $past(mpe_evt[0] && st.pere[0]))
    else $error("Master parity status set without enabled cause");

  a_mpe_irq_mask: assert property (
    $rose(st.isr[1][MPE_BIT]) |-> $past(mpe_evt[1] && !st.imask[1][MPE_BIT]))
    else $error("Master parity interrupt status set while masked");

  a_dpe_irq_set: assert property (
    dpe_evt[1] && !st.imask[1][DPE_BIT] |=> st.isr[1][DPE_BIT])
    else $error("Detected parity interrupt status not set");

  a_read_one_wait: assert property (
    accept && !hwrite && st.bus != B_RDW |=> !hreadyout ##1 hreadyout)
    else $error("Read data phase not one wait state");

  c_bus_read: cover property (st.bus == B_RDD && st.mapped);

  c_both_ports: cover property (dpe_evt[0] && dpe_evt[1]);

endmodule

/* src/translation_port_parity.sv */
`timescale 1ns/1ps
module translation_port_parity
  import parity_err_pkg::*;
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Configuration.
  input  wire logic        pere,
  // Data phase view of the PCI engine.
  input  wire logic        xfer_active,
  input  wire logic [1:0]  xfer_kind,
  input  wire logic        dphase,
  input  wire logic [31:0] ad,
  input  wire logic        exp_par,
  input  wire logic        par,
  // Parity error pin.
  input  wire logic        perr_in_n,
  output logic             perr_out_n,
  output logic             perr_oe,
  // Read data towards the internal bus.
  output logic [31:0]      rd_data,
  output logic             rd_valid,
  output logic             rd_bad,
  // Transaction flow.
  input  wire logic        eng_cmpl_req,
  input  wire logic        tgt_disc,
  input  wire logic        owq_empty,
  input  wire logic        iq_full,
  output logic             mst_cmpl,
  output logic             restart_req,
  output logic             tgt_accept,
  // Error events.
  output logic             mpe_evt,
  output logic             dpe_evt
);

  typedef struct packed {
    logic        ph_valid;
    logic [1:0]  ph_kind;
    logic        ph_par;
    logic [31:0] ph_data;
    logic        perr_drv;
    logic        perr_tail;
    logic        mpe;
    logic        dpe;
    logic [31:0] rd_data;
    logic        rd_valid;
    logic        rd_bad;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;
  logic        bad;
  logic        chk_err;
  logic        wr_perr;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st          = st;
    next_st.ph_valid = dphase && xfer_active;
    next_st.ph_kind  = xfer_kind;
    next_st.ph_par   = exp_par;
    next_st.ph_data  = ad;
    // PAR lags its data phase by one clock, so the check runs a cycle late.
    bad     = st.ph_valid && (par != st.ph_par);
    chk_err = bad && (st.ph_kind == KIND_OUT_RD || st.ph_kind == KIND_IN_WR);
    next_st.perr_drv  = chk_err && pere;
    next_st.perr_tail = st.perr_drv;
    // While mastering a write, the pin belongs to the target.
    wr_perr     = xfer_active && xfer_kind == KIND_OUT_WR && !perr_in_n;
    next_st.mpe = (bad && st.ph_kind == KIND_OUT_RD) || wr_perr;
    next_st.dpe = chk_err;
    next_st.rd_valid = st.ph_valid && st.ph_kind == KIND_OUT_RD;
    if (next_st.rd_valid) begin
      // Bad data is still delivered; only a flag travels with it.
      next_st.rd_data = st.ph_data;
      next_st.rd_bad  = bad;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // PERR# is driven high for one clock after its low pulse before release.
  assign perr_out_n = !st.perr_drv;
  assign perr_oe    = st.perr_drv || st.perr_tail;
  assign rd_data    = st.rd_data;
  assign rd_valid   = st.rd_valid;
  assign rd_bad     = st.rd_bad;
  assign mpe_evt    = st.mpe;
  assign dpe_evt    = st.dpe;

  // A parity error has no path into completion or retry decisions.
  assign mst_cmpl    = eng_cmpl_req;
  assign restart_req = xfer_kind == KIND_OUT_WR && tgt_disc && !owq_empty;
  assign tgt_accept  = xfer_active && xfer_kind == KIND_IN_WR && !iq_full;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_perr_out_read: assert property (
    st.ph_valid && st.ph_kind == KIND_OUT_RD && par != st.ph_par && pere
    |=> !perr_out_n && perr_oe ##1 perr_out_n && perr_oe)
    else $error("PERR# not driven two clocks after outbound read parity error");

  a_perr_in_write: assert property (
    st.ph_valid && st.ph_kind == KIND_IN_WR && par != st.ph_par && pere
    |=> !perr_out_n && perr_oe)
    else $error("PERR# not driven two clocks after inbound write parity error");

  a_perr_has_cause: assert property (
    !perr_out_n |-> $past(st.ph_valid && par != st.ph_par && pere))
    else $error("PERR# asserted without an enabled parity error");

  a_in_read_silent: assert property (
    st.ph_valid && st.ph_kind == KIND_IN_RD && !(xfer_active && xfer_kind == KIND_OUT_WR)
    |=> !mpe_evt && !dpe_evt && perr_out_n)
    else $error("Inbound read parity error caused an action");

  a_read_pass: assert property (
    st.ph_valid && st.ph_kind == KIND_OUT_RD
    |=> rd_valid && rd_data == $past(st.ph_data) && rd_bad == $past(par != st.ph_par))
    else $error("Outbound read data not passed on unchanged");

  a_write_perr: assert property (
    xfer_active && xfer_kind == KIND_OUT_WR && !perr_in_n |=> mpe_evt)
    else $error("Target PERR# on outbound write not recorded");

  a_in_write_accept: assert property (
    xfer_active && xfer_kind == KIND_IN_WR && !iq_full && dpe_evt |-> tgt_accept)
    else $error("Inbound write refused after parity error");

  a_perr_release: assert property (
    $fell(perr_oe) |-> $past(perr_out_n))
    else $error("PERR# released while low");

  c_read_error: cover property (
    st.ph_valid && st.ph_kind == KIND_OUT_RD && par != st.ph_par && pere);

  c_write_perr: cover property (xfer_active && xfer_kind == KIND_OUT_WR && !perr_in_n);

endmodule

/* tb/pci_data_parity_error_handler_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module pci_data_parity_error_handler_test
  import parity_err_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout;
  logic [1:0] act, dph, par, drv, cmpl_req, disc, owq_empty, iq_full;
  logic [1:0][1:0] kind;
  logic [1:0][31:0] ad, rdd;
  logic [1:0][3:0] cbe_n;
  logic [1:0] out_n, oe, rdv, rdb, mcmp, rst_req, acc;
  wire logic [1:0] perr;
  int failures = 0;
  int total_checks = 0;

  // PERR# has a pull-up, so a released pin reads high.
  assign perr[0] = oe[0] ? out_n[0] : ~drv[0];
  assign perr[1] = oe[1] ? out_n[1] : ~drv[1];

  pci_peer pci_peer_i (.hclk(hclk), .xfer_active(act), .xfer_kind(kind), .dphase(dph),
    .ad(ad), .cbe_n(cbe_n), .par(par), .perr_drive(drv));

  pci_data_parity_error_handler pci_data_parity_error_handler_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pri_xfer_active(act[0]), .pri_xfer_kind(kind[0]), .pri_dphase(dph[0]),
    .pri_ad(ad[0]), .pri_cbe_n(cbe_n[0]), .pri_par(par[0]),
    .primary_parity_err_n_in(perr[0]), .primary_parity_err_n_out(out_n[0]),
    .primary_parity_err_oe(oe[0]), .pri_rd_data(rdd[0]), .pri_rd_valid(rdv[0]),
    .pri_rd_bad(rdb[0]), .pri_eng_cmpl_req(cmpl_req[0]), .pri_tgt_disc(disc[0]),
    .pri_owq_empty(owq_empty[0]), .pri_iq_full(iq_full[0]), .pri_mst_cmpl(mcmp[0]),
    .pri_restart_req(rst_req[0]), .pri_tgt_accept(acc[0]),
    .sec_xfer_active(act[1]), .sec_xfer_kind(kind[1]), .sec_dphase(dph[1]),
    .sec_ad(ad[1]), .sec_cbe_n(cbe_n[1]), .sec_par(par[1]),
    .secondary_parity_err_n_in(perr[1]), .secondary_parity_err_n_out(out_n[1]),
    .secondary_parity_err_oe(oe[1]), .sec_rd_data(rdd[1]), .sec_rd_valid(rdv[1]),
    .sec_rd_bad(rdb[1]), .sec_eng_cmpl_req(cmpl_req[1]), .sec_tgt_disc(disc[1]),
    .sec_owq_empty(owq_empty[1]), .sec_iq_full(iq_full[1]), .sec_mst_cmpl(mcmp[1]),
    .sec_restart_req(rst_req[1]), .sec_tgt_accept(acc[1]));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    `CHK("reg", e, r)
  endtask

  function automatic logic [31:0] at(input int p, input logic [31:0] ofs);
    return ofs + (p != 0 ? OFS_SEC_CMD : 32'h0);
  endfunction

  task automatic setup(input int p, input logic pe, input logic [1:0] m);
    logic [31:0] r;
    ahb(1'b1, at(p, OFS_PRI_CMD), {31'h0, pe}, r);
    ahb(1'b1, at(p, OFS_PRI_IMASK), {30'h0, m}, r);
  endtask

  // Status and irq status are compared, the other port is seen quiet, then both clear.
  task automatic regs(input int p, input logic [1:0] s, input logic [1:0] i);
    logic [31:0] r;
    rdchk(at(p, OFS_PRI_STS), {30'h0, s});
    rdchk(at(p, OFS_PRI_ISR), {30'h0, i});
    rdchk(at(1 - p, OFS_PRI_STS), 32'h0);
    ahb(1'b1, at(p, OFS_PRI_STS), 32'h3, r);
    ahb(1'b1, at(p, OFS_PRI_ISR), 32'h3, r);
    rdchk(at(p, OFS_PRI_STS), 32'h0);
  endtask

  // Pin level two and three clocks after the phase, then release.
  task automatic pin(input int p, input logic e);
    #1;
    `CHK("perr_low", ~e, perr[p])
    @(posedge hclk);
    #1;
    `CHK("perr_oe", e, oe[p])
    `CHK("perr_high", 1'b1, perr[p])
    @(posedge hclk);
    #1;
    `CHK("perr_free", 1'b0, oe[p])
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic oread(input int p, input logic pe, input logic [1:0] m, input logic bad);
    logic [31:0] d;
    d = 32'h5a00_00c3 ^ p;
    setup(p, pe, m);
    pci_peer_i.phase(p, KIND_OUT_RD, d, 4'h0, bad);
    // Read data and the PERR# low stand in the clock right after the check edge.
    #1;
    `CHK("rd_valid", 1'b1, rdv[p])
    `CHK("rd_data", d, rdd[p])
    `CHK("rd_bad", bad, rdb[p])
    `CHK("no_cmpl", 1'b0, mcmp[p])
    `CHK("perr_low", ~(pe & bad), perr[p])
    @(posedge hclk);
    #1;
    `CHK("perr_oe", pe & bad, oe[p])
    pci_peer_i.idle(p);
    regs(p, {bad, pe & bad}, {bad & ~m[1], bad & ~m[0]});
  endtask

  task automatic iwrite(input int p, input logic pe);
    setup(p, pe, 2'h0);
    pci_peer_i.phase(p, KIND_IN_WR, 32'h0f0f_1234, 4'ha, 1'b1);
    `CHK("accept", 1'b1, acc[p])
    iq_full[p] <= 1'b1;
    #1;
    `CHK("full_stop", 1'b0, acc[p])
    iq_full[p] <= 1'b0;
    pin(p, pe);
    pci_peer_i.idle(p);
    regs(p, 2'h2, 2'h2);
  endtask

  task automatic iread(input int p);
    setup(p, 1'b1, 2'h0);
    pci_peer_i.phase(p, KIND_IN_RD, 32'h8000_0001, 4'h3, 1'b1);
    pin(p, 1'b0);
    `CHK("no_rd", 1'b0, rdv[p])
    pci_peer_i.report(p);
    pci_peer_i.idle(p);
    regs(p, 2'h0, 2'h0);
  endtask

  task automatic owrite(input int p, input logic pe, input logic [1:0] m);
    setup(p, pe, m);
    disc[p] <= 1'b1;
    owq_empty[p] <= 1'b0;
    pci_peer_i.phase(p, KIND_OUT_WR, 32'h1357_9bdf, 4'h0, 1'b0);
    pci_peer_i.report(p);
    #1;
    `CHK("restart", 1'b1, rst_req[p])
    `CHK("no_cmpl", 1'b0, mcmp[p])
    owq_empty[p] <= 1'b1;
    cmpl_req[p] <= 1'b1;
    #1;
    `CHK("drained", 1'b0, rst_req[p])
    `CHK("cmpl", 1'b1, mcmp[p])
    cmpl_req[p] <= 1'b0;
    disc[p] <= 1'b0;
    pci_peer_i.idle(p);
    regs(p, {1'b0, pe}, {1'b0, ~m[0]});
  endtask

  task summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {cmpl_req, disc, iq_full} = '0;
    owq_empty = 2'h3;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 36; a += 4) rdchk(a, 32'h0);
    ahb(1'b1, 32'h20, 32'hffff_ffff, r);
    rdchk(32'h20, 32'h0);
    `CHK("hresp", 1'b0, hresp)
    oread(0, 1'b1, 2'h0, 1'b1);
    oread(1, 1'b1, 2'h0, 1'b1);
    oread(0, 1'b0, 2'h3, 1'b1);
    oread(1, 1'b0, 2'h1, 1'b1);
    oread(0, 1'b1, 2'h0, 1'b0);
    iwrite(0, 1'b1);
    iwrite(1, 1'b0);
    iread(1);
    owrite(0, 1'b1, 2'h0);
    owrite(1, 1'b0, 2'h1);
    summarize();
  end

  // A hang stops the run well after the sequence should have ended.
  initial begin
    #(25 * 5000);
    failures++;
    summarize();
  end
endmodule

/* tb/pci_peer.sv */
`timescale 1ns/1ps
module pci_peer (
  // Clock.
  input  wire logic        hclk,
  // Lines driven towards each port.
  output logic [1:0]       xfer_active,
  output logic [1:0][1:0]  xfer_kind,
  output logic [1:0]       dphase,
  output logic [1:0][31:0] ad,
  output logic [1:0][3:0]  cbe_n,
  output logic [1:0]       par,
  output logic [1:0]       perr_drive
);
  initial begin
    xfer_active = 2'h0;
    xfer_kind = '0;
    dphase = 2'h0;
    ad = '0;
    cbe_n = '0;
    par = 2'h0;
    perr_drive = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One data phase; a set bad flag flips the parity bit.
  task automatic phase(input int p, input logic [1:0] k, input logic [31:0] d,
                       input logic [3:0] c, input logic bad);
    @(posedge hclk);
    xfer_active[p] <= 1'b1;
    xfer_kind[p] <= k;
    dphase[p] <= 1'b1;
    ad[p] <= d;
    cbe_n[p] <= c;
    @(posedge hclk);
    dphase[p] <= 1'b0;
    // The lines move on after the phase so stale data cannot pass for valid.
    ad[p] <= ~d;
    par[p] <= (^{d, c}) ^ bad;
    @(posedge hclk);
    par[p] <= ~par[p];
  endtask

  // Target side reports a fault for one clock.
  task automatic report(input int p);
    @(posedge hclk);
    perr_drive[p] <= 1'b1;
    @(posedge hclk);
    perr_drive[p] <= 1'b0;
  endtask

  task automatic idle(input int p);
    @(posedge hclk);
    xfer_active[p] <= 1'b0;
  endtask
endmodule
